/* File: common/dbg_link_cfg.svh */
`ifndef DBG_LINK_CFG_SVH
`define DBG_LINK_CFG_SVH

// serial tick = clk / 8 (clk stands for the vco clock)
`define DBG_VCO_DIV 4'h8
// low ticks beyond which a low level is a timing reference request
`define DBG_SYNC_LOW_TICKS 10'h080
// quiet ticks after the request ends before the answer
`define DBG_SYNC_DELAY_TICKS 10'h010
// low ticks of the timing reference answer
`define DBG_RESP_LOW_TICKS 10'h080
// ticks between falling edges before a soft reset
`define DBG_TIMEOUT_TICKS 10'h200
// low ticks of a handshake pulse
`define DBG_ACK_LOW_TICKS 10'h010
// a low pulse this long or longer carries a zero
`define DBG_BIT_ZERO_MIN 10'h00A
// host bit shapes, in target ticks
`define DBG_BIT1_LOW 16'h0004
`define DBG_BIT0_LOW 16'h000D
`define DBG_BIT_PERIOD 16'h0010
// host request length in clk: 128 ticks, 8 clk each, slowest clock 2x
`define DBG_HOST_REQ_CLKS 16'h0800
// right shift that divides a measured answer by 128
`define DBG_RESP_SHIFT 7

`endif

/* File: common/dbg_link_pkg.sv */
package dbg_link_pkg;

  typedef enum logic [2:0] {
    D_IDLE,
    D_LOW,
    D_WAIT_HIGH,
    D_DELAY,
    D_RESP,
    D_SPEED,
    D_ACK,
    D_ACK_SPEED
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_REQ,
    H_SPEED,
    H_LISTEN,
    H_MEAS,
    H_BIT_LOW,
    H_BIT_HIGH
  } host_state_t;

  typedef struct packed {
    dev_state_t st;
    logic [2:0] div;
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [9:0] lcnt;
    logic [9:0] tcnt;
    logic [4:0] bits;
    logic [15:0] shreg;
    logic cmd_vld;
    logic [15:0] cmd;
    logic soft_rst;
    logic sync_seen;
    logic rd_busy;
    logic rd_acked;
    logic hs;
    logic ack_pend;
    logic step_busy;
    logic lp;
    logic dbg_act;
    logic go;
    logic stack;
    logic isr_pc;
    logic drv_low;
    logic drv_high;
  } dev_st_t;

  typedef struct packed {
    host_state_t st;
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic [15:0] cnt;
    logic [15:0] tk;
    logic [15:0] sync_clks;
    logic [15:0] bit_clks;
    logic [4:0] bitn;
    logic [15:0] shreg;
    logic sync_done;
    logic ack_ok;
    logic drv_low;
    logic drv_high;
  } host_st_t;

endpackage : dbg_link_pkg

/* File: common/dbg_link_if.sv */
`timescale 1ns/1ps
interface dbg_link_if;
  logic tgt_out;
  logic tgt_oe_n;
  logic host_out;
  logic host_oe_n;
  logic line;

  // open-drain wire with pull-up: low when either end drives low
  assign line = !((!tgt_oe_n && !tgt_out) || (!host_oe_n && !host_out));

  modport target (
    output tgt_out,
    output tgt_oe_n,
    input line
  );

  modport host (
    output host_out,
    output host_oe_n,
    input line
  );
endinterface : dbg_link_if

/* File: hw/dbg_target.sv */
`timescale 1ns/1ps
`include "dbg_link_cfg.svh"

// Behaviour
// [R1] host holds line low long, then speedup
// [R2] serial tick is clk divided by eight
// [R3] request discards partial command or bit
// [R4] wait sixteen ticks after line returns high
// [R5] answer low 128 ticks, speedup, release
// [R6] host derives bit timing from answer
// [R7] next falling edge starts command or request
// [R8] request also cancels pending handshake pulse
// [R9] step runs one instruction, back to debug
// [R10] pending interrupt: stacking only, no instruction
// [R11] host never steps soft breakpoint halt instruction
// [R12] stepped stop/wait holds step; background blocked
// [R13] system stop: no command accepted
// [R14] leaving low power: debug, pc at service
// [R15] drop step handshake over low power
// [R16] handshake off only on system stop; the code also clears it on hs_off
// [R17] host re-enables handshake after system stop
// [R18] low beyond 128 ticks is request, no timeout
// [R19] 512 ticks without edge mid-command: soft reset
// [R20] unretrieved read data dropped after 512 ticks
// [R21] handshake on: no timeout until read pulse
// [R22] after timeout next edge starts fresh
// [R23] handshake disabled after reset
// [R24] timeout restarts on every falling edge
module dbg_target #(
  parameter logic [4:0] CMD_BITS = 5'h08,
  parameter logic [4:0] DATA_BITS = 5'h08
) (
  input wire logic clk,
  input wire logic sys_rst,
  dbg_link_if.target lnk,
  input wire logic hs_on,
  input wire logic hs_off,
  input wire logic ack_req,
  input wire logic rd_start,
  input wire logic step_cmd,
  input wire logic irq_pending,
  input wire logic instr_done,
  input wire logic lp_enter,
  input wire logic lp_exit,
  input wire logic bg_enter,
  input wire logic sys_stop,
  output logic cmd_valid,
  output logic [15:0] cmd_data,
  output logic soft_reset,
  output logic sync_seen,
  output logic step_go,
  output logic step_stack_irq,
  output logic pc_to_isr,
  output logic debug_active,
  output logic handshake_en,
  output logic read_pending,
  output logic bg_cmd_allowed,
  output logic cmd_allowed
);

  dbg_link_pkg::dev_st_t r_r;
  dbg_link_pkg::dev_st_t r_nxt;

  logic tick;
  logic fall;
  logic rise;
  logic tmo_arm;
  logic bitv;
  logic ack_set;
  logic rd_new;

  function automatic logic at_last(input logic [9:0] c,
                                   input logic [9:0] lim);
    return c == lim - 10'h001;
  endfunction : at_last

  // serial tick from the vco-rate clock
  assign tick = ({1'b0, r_r.div} == `DBG_VCO_DIV - 4'h1); // [R2]
  // filtered edges: second and third stage must agree
  assign fall = r_r.lvl && (r_r.s2 == r_r.s3) && !r_r.s3;
  assign rise = !r_r.lvl && (r_r.s2 == r_r.s3) && r_r.s3;
  assign bitv = (r_r.lcnt < `DBG_BIT_ZERO_MIN);
  // mid-command, or read waiting outside the handshake wait
  assign tmo_arm = (r_r.bits != 5'h00) ||
                   (r_r.rd_busy && !(r_r.hs && !r_r.rd_acked)); // [R21]
  // new requests win over a clear that falls in the same cycle
  assign ack_set = r_r.hs && (ack_req ||
    (r_r.step_busy && !r_r.lp && !lp_enter && instr_done));
  assign rd_new = rd_start && !sys_stop;

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.s1 = lnk.line;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    if (r_r.s2 == r_r.s3)
    begin
      r_nxt.lvl = r_r.s3;
    end
    r_nxt.div = tick ? 3'h0 : r_r.div + 3'h1; // [R2]
    r_nxt.cmd_vld = 1'b0;
    r_nxt.soft_rst = 1'b0;
    r_nxt.sync_seen = 1'b0;
    r_nxt.go = 1'b0;
    r_nxt.stack = 1'b0;
    r_nxt.isr_pc = 1'b0;

    if (hs_on)
    begin
      r_nxt.hs = 1'b1;
    end
    if (hs_off || sys_stop)
    begin
      r_nxt.hs = 1'b0; // [R16]
    end
    if (ack_set)
    begin
      r_nxt.ack_pend = 1'b1;
    end
    if (rd_new)
    begin
      r_nxt.rd_busy = 1'b1;
      r_nxt.rd_acked = 1'b0;
      r_nxt.bits = 5'h00;
    end
    if (bg_enter)
    begin
      r_nxt.dbg_act = 1'b1;
    end

    // single step
    if (step_cmd && r_r.dbg_act && !r_r.step_busy && !sys_stop) // [R13]
    begin
      r_nxt.step_busy = 1'b1;
      r_nxt.dbg_act = 1'b0;
      if (irq_pending)
      begin
        r_nxt.stack = 1'b1; // [R10]
      end
      else
      begin
        r_nxt.go = 1'b1; // [R9]
      end
    end
    if (r_r.step_busy && !r_r.lp && lp_enter)
    begin
      r_nxt.lp = 1'b1; // [R12]
    end
    else if (r_r.step_busy && !r_r.lp && instr_done)
    begin
      r_nxt.step_busy = 1'b0;
      r_nxt.dbg_act = 1'b1; // [R9]
    end
    if (r_r.lp && lp_exit)
    begin
      // no handshake for this step
      r_nxt.lp = 1'b0; // [R15]
      r_nxt.step_busy = 1'b0;
      r_nxt.dbg_act = 1'b1; // [R14]
      r_nxt.isr_pc = 1'b1; // [R14]
    end

    case (r_r.st)
      dbg_link_pkg::D_IDLE:
      begin
        if (fall && !sys_stop) // [R13]
        begin
          r_nxt.st = dbg_link_pkg::D_LOW; // [R7] [R22]
          r_nxt.lcnt = 10'h000;
          r_nxt.tcnt = 10'h000; // [R24]
        end
        else if (tick && tmo_arm)
        begin
          if (at_last(r_r.tcnt, `DBG_TIMEOUT_TICKS))
          begin
            r_nxt.bits = 5'h00; // [R19]
            r_nxt.rd_busy = rd_new; // [R20]
            r_nxt.soft_rst = 1'b1; // [R22]
            r_nxt.tcnt = 10'h000;
          end
          else
          begin
            r_nxt.tcnt = r_r.tcnt + 10'h001;
          end
        end
        else if (tick && r_r.ack_pend && r_r.lvl)
        begin
          r_nxt.st = dbg_link_pkg::D_ACK;
          r_nxt.ack_pend = ack_set;
          r_nxt.lcnt = 10'h000;
          r_nxt.drv_low = 1'b1;
        end
        if (!tmo_arm)
        begin
          r_nxt.tcnt = 10'h000;
        end
      end
      dbg_link_pkg::D_LOW:
      begin
        if (rise)
        begin
          r_nxt.st = dbg_link_pkg::D_IDLE;
          // timeout runs from the fall, so the low time counts
          r_nxt.tcnt = r_r.lcnt; // [R24] [R19]
          r_nxt.shreg = {r_r.shreg[14:0], bitv};
          r_nxt.bits = r_r.bits + 5'h01;
          if (r_r.rd_busy && r_r.bits == DATA_BITS - 5'h01)
          begin
            r_nxt.rd_busy = rd_new;
            r_nxt.bits = 5'h00;
          end
          else if (!r_r.rd_busy && r_r.bits == CMD_BITS - 5'h01)
          begin
            r_nxt.cmd_vld = 1'b1;
            r_nxt.cmd = {r_r.shreg[14:0], bitv};
            r_nxt.bits = 5'h00;
          end
        end
        else if (tick)
        begin
          if (r_r.lcnt == `DBG_SYNC_LOW_TICKS) // [R18]
          begin
            r_nxt.st = dbg_link_pkg::D_WAIT_HIGH;
            r_nxt.sync_seen = 1'b1;
            r_nxt.soft_rst = 1'b1; // [R3]
            r_nxt.bits = 5'h00; // [R3]
            r_nxt.rd_busy = rd_new; // [R3]
            r_nxt.ack_pend = ack_set; // [R8]
          end
          else
          begin
            r_nxt.lcnt = r_r.lcnt + 10'h001;
          end
        end
      end
      dbg_link_pkg::D_WAIT_HIGH:
      begin
        // waits without limit for the host to let go
        if (rise)
        begin
          r_nxt.st = dbg_link_pkg::D_DELAY; // [R18] [R3]
          r_nxt.lcnt = 10'h000;
        end
      end
      dbg_link_pkg::D_DELAY:
      begin
        if (tick)
        begin
          r_nxt.lcnt = r_r.lcnt + 10'h001;
          if (at_last(r_r.lcnt, `DBG_SYNC_DELAY_TICKS)) // [R4]
          begin
            r_nxt.st = dbg_link_pkg::D_RESP;
            r_nxt.lcnt = 10'h000;
            r_nxt.drv_low = 1'b1;
          end
        end
      end
      dbg_link_pkg::D_RESP:
      begin
        if (tick)
        begin
          r_nxt.lcnt = r_r.lcnt + 10'h001;
          if (at_last(r_r.lcnt, `DBG_RESP_LOW_TICKS)) // [R5]
          begin
            r_nxt.st = dbg_link_pkg::D_SPEED;
            r_nxt.drv_low = 1'b0;
            r_nxt.drv_high = 1'b1;
          end
        end
      end
      dbg_link_pkg::D_SPEED, dbg_link_pkg::D_ACK_SPEED:
      begin
        if (tick)
        begin
          r_nxt.st = dbg_link_pkg::D_IDLE; // [R5] [R7]
          r_nxt.drv_high = 1'b0;
          r_nxt.bits = 5'h00;
          r_nxt.tcnt = 10'h000;
        end
      end
      dbg_link_pkg::D_ACK:
      begin
        if (tick)
        begin
          r_nxt.lcnt = r_r.lcnt + 10'h001;
          if (at_last(r_r.lcnt, `DBG_ACK_LOW_TICKS))
          begin
            r_nxt.st = dbg_link_pkg::D_ACK_SPEED;
            r_nxt.drv_low = 1'b0;
            r_nxt.drv_high = 1'b1;
            r_nxt.rd_acked = r_r.rd_busy; // [R21]
          end
        end
      end
      default:
      begin
        r_nxt.st = dbg_link_pkg::D_IDLE;
        r_nxt.drv_low = 1'b0;
        r_nxt.drv_high = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_r <= '0; // [R23]
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign lnk.tgt_out = r_r.drv_high;
  assign lnk.tgt_oe_n = !(r_r.drv_low || r_r.drv_high);
  assign cmd_valid = r_r.cmd_vld;
  assign cmd_data = r_r.cmd;
  assign soft_reset = r_r.soft_rst;
  assign sync_seen = r_r.sync_seen;
  assign step_go = r_r.go;
  assign step_stack_irq = r_r.stack;
  assign pc_to_isr = r_r.isr_pc;
  assign debug_active = r_r.dbg_act;
  assign handshake_en = r_r.hs;
  assign read_pending = r_r.rd_busy;
  assign bg_cmd_allowed = !r_r.lp && !sys_stop; // [R12]
  assign cmd_allowed = !sys_stop; // [R13]

endmodule : dbg_target

/* File: hw/dbg_host.sv */
`timescale 1ns/1ps
`include "dbg_link_cfg.svh"

module dbg_host #(
  parameter logic [15:0] REQ_CLKS = `DBG_HOST_REQ_CLKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  dbg_link_if.host lnk,
  input wire logic sync_start,
  input wire logic send_start,
  input wire logic [15:0] send_data,
  input wire logic [4:0] send_bits,
  input wire logic hs_enable_sent,
  input wire logic sys_stop_seen,
  input wire logic next_is_halt,
  output logic busy,
  output logic sync_done,
  output logic [15:0] sync_clks,
  output logic [15:0] bit_clks,
  output logic ack_trusted,
  output logic step_allowed
);

  dbg_link_pkg::host_st_t r_r;
  dbg_link_pkg::host_st_t r_nxt;

  logic fall;
  logic rise;
  logic tick;
  logic [15:0] low_ticks;

  assign fall = r_r.lvl && (r_r.s2 == r_r.s3) && !r_r.s3;
  assign rise = !r_r.lvl && (r_r.s2 == r_r.s3) && r_r.s3;
  assign tick = (r_r.tk == r_r.bit_clks - 16'h0001);
  assign low_ticks = r_r.shreg[15] ? `DBG_BIT1_LOW : `DBG_BIT0_LOW;

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.s1 = lnk.line;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    if (r_r.s2 == r_r.s3)
    begin
      r_nxt.lvl = r_r.s3;
    end
    r_nxt.sync_done = 1'b0;
    if (hs_enable_sent)
    begin
      r_nxt.ack_ok = 1'b1;
    end
    if (sys_stop_seen)
    begin
      r_nxt.ack_ok = 1'b0; // [R17]
    end
    case (r_r.st)
      dbg_link_pkg::H_IDLE, dbg_link_pkg::H_LISTEN:
      begin
        if (sync_start)
        begin
          r_nxt.st = dbg_link_pkg::H_REQ;
          r_nxt.cnt = 16'h0000;
          r_nxt.drv_low = 1'b1;
        end
        else if (r_r.st == dbg_link_pkg::H_LISTEN && fall)
        begin
          r_nxt.st = dbg_link_pkg::H_MEAS;
          // the edge that saw the fall is the first low clk
          r_nxt.cnt = 16'h0001;
        end
        else if (r_r.st == dbg_link_pkg::H_IDLE && send_start &&
                 send_bits != 5'h00)
        begin
          r_nxt.st = dbg_link_pkg::H_BIT_LOW;
          r_nxt.shreg = send_data << (5'h10 - send_bits);
          r_nxt.bitn = send_bits;
          r_nxt.cnt = 16'h0000;
          r_nxt.tk = 16'h0000;
          r_nxt.drv_low = 1'b1;
        end
      end
      dbg_link_pkg::H_REQ:
      begin
        r_nxt.cnt = r_r.cnt + 16'h0001;
        if (r_r.cnt == REQ_CLKS - 16'h0001) // [R1]
        begin
          r_nxt.st = dbg_link_pkg::H_SPEED;
          r_nxt.drv_low = 1'b0;
          r_nxt.drv_high = 1'b1;
        end
      end
      dbg_link_pkg::H_SPEED:
      begin
        r_nxt.st = dbg_link_pkg::H_LISTEN; // [R1]
        r_nxt.drv_high = 1'b0;
      end
      dbg_link_pkg::H_MEAS:
      begin
        r_nxt.cnt = r_r.cnt + 16'h0001;
        if (rise)
        begin
          r_nxt.st = dbg_link_pkg::H_IDLE;
          r_nxt.sync_clks = r_r.cnt;
          r_nxt.bit_clks = r_r.cnt >> `DBG_RESP_SHIFT; // [R6]
          if ((r_r.cnt >> `DBG_RESP_SHIFT) == 16'h0000)
          begin
            r_nxt.bit_clks = 16'h0001;
          end
          r_nxt.sync_done = 1'b1;
        end
      end
      dbg_link_pkg::H_BIT_LOW, dbg_link_pkg::H_BIT_HIGH:
      begin
        r_nxt.tk = tick ? 16'h0000 : r_r.tk + 16'h0001;
        if (tick)
        begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
          if (r_r.cnt + 16'h0001 == low_ticks)
          begin
            r_nxt.st = dbg_link_pkg::H_BIT_HIGH;
            r_nxt.drv_low = 1'b0;
          end
          if (r_r.cnt == `DBG_BIT_PERIOD - 16'h0001)
          begin
            r_nxt.cnt = 16'h0000;
            r_nxt.shreg = {r_r.shreg[14:0], 1'b0};
            r_nxt.bitn = r_r.bitn - 5'h01;
            if (r_r.bitn == 5'h01)
            begin
              r_nxt.st = dbg_link_pkg::H_IDLE;
            end
            else
            begin
              r_nxt.st = dbg_link_pkg::H_BIT_LOW;
              r_nxt.drv_low = 1'b1;
            end
          end
        end
      end
      default:
      begin
        r_nxt.st = dbg_link_pkg::H_IDLE;
        r_nxt.drv_low = 1'b0;
        r_nxt.drv_high = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_r <= '0;
      r_r.bit_clks <= 16'h0008;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign lnk.host_out = r_r.drv_high;
  assign lnk.host_oe_n = !(r_r.drv_low || r_r.drv_high);
  assign busy = (r_r.st != dbg_link_pkg::H_IDLE);
  assign sync_done = r_r.sync_done;
  assign sync_clks = r_r.sync_clks;
  assign bit_clks = r_r.bit_clks;
  assign ack_trusted = r_r.ack_ok;
  assign step_allowed = !next_is_halt; // [R11]

endmodule : dbg_host

/* File: dv/dbg_link_asserts.sv */
`timescale 1ns/1ps
module dbg_link_asserts #(
  parameter logic [15:0] REQ_CLKS = 16'h0800
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tgt_out,
  input wire logic tgt_oe_n,
  input wire logic host_out,
  input wire logic host_oe_n,
  input wire logic line
);
  logic [15:0] tlow_r, hlow_r, llow_r, lhi_r;
  logic sync_r;
  wire t_spd = !tgt_oe_n && tgt_out;
  wire h_spd = !host_oe_n && host_out;

  // run lengths of each driver's low, of line low and of line high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tlow_r <= 16'h0000;
      hlow_r <= 16'h0000;
      llow_r <= 16'h0000;
      lhi_r <= 16'h0000;
      sync_r <= 1'b0;
    end
    else
    begin
      tlow_r <= (!tgt_oe_n && !tgt_out) ? tlow_r + 16'h0001 : 16'h0000;
      hlow_r <= (!host_oe_n && !host_out) ? hlow_r + 16'h0001 : 16'h0000;
      llow_r <= !line ? llow_r + 16'h0001 : 16'h0000;
      lhi_r <= line ? lhi_r + 16'h0001 : 16'h0000;
      // set by a long request, cleared by the answer's speedup
      if (llow_r > 16'h0410)
        sync_r <= 1'b1;
      else if (t_spd)
        sync_r <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sync_answer_len_a: assert property (
    (t_spd && $rose(tgt_out) && sync_r) |-> tlow_r == 16'h0400)
    else $error("timing answer low length wrong");
  ack_pulse_len_a: assert property (
    (t_spd && $rose(tgt_out) && !sync_r) |-> tlow_r == 16'h0080)
    else $error("handshake pulse low length wrong");
  tgt_speedup_a: assert property (
    (t_spd && $rose(tgt_out)) |-> t_spd[*8] ##1 tgt_oe_n)
    else $error("target speedup not one tick then release");
  sync_delay_a: assert property (
    ($fell(tgt_oe_n) && sync_r) |-> lhi_r >= 16'h007D && lhi_r <= 16'h0091)
    else $error("answer started off the sixteen tick delay");
  sync_answer_due_a: assert property (
    ($rose(line) && llow_r > 16'h0410) |-> ##[120:150] !tgt_oe_n)
    else $error("no answer after timing request");
  host_req_len_a: assert property (
    ($rose(host_out) && h_spd && hlow_r > 16'h0400) |-> hlow_r == REQ_CLKS)
    else $error("host request low length wrong");
  host_release_a: assert property (
    ($rose(host_out) && h_spd && hlow_r > 16'h0400) |=> host_oe_n)
    else $error("host did not release after speedup");
  no_clash_a: assert property (
    !tgt_oe_n |-> host_oe_n)
    else $error("both ends drive the line");
endmodule : dbg_link_asserts

/* File: dv/test_debug_line_sync_timeout_trace.sv */
`timescale 1ns/1ps
module test_debug_line_sync_timeout_trace;
  logic clk, sys_rst, irq_pending, sys_stop, send_start, next_is_halt;
  logic [11:0] pl;
  logic [15:0] send_data, cmd_data, sync_clks, bit_clks, got_cmd;
  logic [4:0] send_bits;
  logic cmd_valid, soft_reset, sync_seen, step_go, step_stack_irq, pc_to_isr;
  logic debug_active, handshake_en, read_pending, bg_cmd_allowed;
  logic cmd_allowed, busy, sync_done, ack_trusted, step_allowed;
  logic [7:0] ev;
  int fail_count, tests_run, n;
  dbg_link_if lnk ();
  assign ev = {!lnk.line, sync_done, sync_seen, soft_reset, pc_to_isr,
    step_stack_irq, step_go, cmd_valid};

  dbg_target #(.CMD_BITS(5'h08), .DATA_BITS(5'h08)) i_dbg_target (
    .clk(clk), .sys_rst(sys_rst), .lnk(lnk), .hs_on(pl[0]),
    .hs_off(pl[1]), .ack_req(pl[2]), .rd_start(pl[3]), .step_cmd(pl[4]),
    .irq_pending(irq_pending), .instr_done(pl[5]), .lp_enter(pl[6]),
    .lp_exit(pl[7]), .bg_enter(pl[8]), .sys_stop(sys_stop),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .soft_reset(soft_reset),
    .sync_seen(sync_seen), .step_go(step_go),
    .step_stack_irq(step_stack_irq), .pc_to_isr(pc_to_isr),
    .debug_active(debug_active), .handshake_en(handshake_en),
    .read_pending(read_pending), .bg_cmd_allowed(bg_cmd_allowed),
    .cmd_allowed(cmd_allowed));
  dbg_host #(.REQ_CLKS(16'h0800)) i_dbg_host (
    .clk(clk), .sys_rst(sys_rst), .lnk(lnk), .sync_start(pl[9]),
    .send_start(send_start), .send_data(send_data), .send_bits(send_bits),
    .hs_enable_sent(pl[10]), .sys_stop_seen(pl[11]),
    .next_is_halt(next_is_halt), .busy(busy), .sync_done(sync_done),
    .sync_clks(sync_clks), .bit_clks(bit_clks), .ack_trusted(ack_trusted),
    .step_allowed(step_allowed));
  dbg_link_asserts #(.REQ_CLKS(16'h0800)) i_dbg_link_asserts (
    .clk(clk), .sys_rst(sys_rst), .tgt_out(lnk.tgt_out),
    .tgt_oe_n(lnk.tgt_oe_n), .host_out(lnk.host_out),
    .host_oe_n(lnk.host_oe_n), .line(lnk.line));

  always @(posedge clk)
    if (cmd_valid === 1'b1)
      got_cmd <= cmd_data;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // one-cycle pulse on a grouped input, returns where outputs are settled
  task pulse(input int b);
    @(posedge clk);
    pl[b] <= 1'b1;
    @(posedge clk);
    pl[b] <= 1'b0;
    @(negedge clk);
  endtask : pulse

  task wait_ev(input int b, input int lim);
    n = 0;
    while (ev[b] !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_ev

  task send(input logic [15:0] d, input logic [4:0] nb);
    @(posedge clk);
    send_data <= d;
    send_bits <= nb;
    send_start <= 1'b1;
    @(posedge clk);
    send_start <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while ((busy !== 1'b0 || n < 2) && n < 3000);
    chk({15'h0000, busy}, 16'h0000);
    repeat (8) @(negedge clk);
  endtask : send

  task do_sync;
    pulse(9);
    wait_ev(5, 1200);
    chk({15'h0000, n >= 1020 && n <= 1060}, 16'h0001);
    chk({15'h0000, ev[4]}, 16'h0001);
    wait_ev(6, 3000);
    chk({15'h0000, sync_clks >= 16'h03FC && sync_clks <= 16'h0404},
      16'h0001);
    chk(bit_clks, 16'h0008);
    // let the answer's speedup tick end before the next command
    repeat (16) @(negedge clk);
  endtask : do_sync

  task t_abort;
    pulse(9);
    repeat (20) @(negedge clk);
    pulse(2);
    wait_ev(6, 4400);
    chk({15'h0000, ev[6]}, 16'h0001);
    repeat (16) @(negedge clk);
    wait_ev(7, 300);
    chk({15'h0000, ev[7]}, 16'h0000);
  endtask : t_abort

  task t_cmd;
    send(16'h00A5, 5'h08);
    chk({8'h00, got_cmd[7:0]}, 16'h00A5);
    send(16'h0005, 5'h03);
    do_sync();
    send(16'h003C, 5'h08);
    chk({8'h00, got_cmd[7:0]}, 16'h003C);
  endtask : t_cmd

  task t_timeout;
    send(16'h0006, 5'h03);
    wait_ev(4, 4400);
    chk({15'h0000, n >= 3940 && n <= 4000}, 16'h0001);
    send(16'h005A, 5'h08);
    chk({8'h00, got_cmd[7:0]}, 16'h005A);
  endtask : t_timeout

  task t_read;
    pulse(3);
    chk({15'h0000, read_pending}, 16'h0001);
    wait_ev(4, 4400);
    chk({15'h0000, read_pending}, 16'h0000);
    pulse(0);
    chk({15'h0000, handshake_en}, 16'h0001);
    pulse(3);
    repeat (4400) @(negedge clk);
    chk({15'h0000, read_pending}, 16'h0001);
    pulse(2);
    wait_ev(7, 100);
    chk({15'h0000, ev[7]}, 16'h0001);
    wait_ev(4, 4400);
    chk({15'h0000, read_pending}, 16'h0000);
  endtask : t_read

  task t_step;
    pulse(8);
    pulse(4);
    wait_ev(1, 4);
    chk({15'h0000, ev[1]}, 16'h0001);
    chk({15'h0000, debug_active}, 16'h0000);
    pulse(5);
    chk({15'h0000, debug_active}, 16'h0001);
    wait_ev(7, 40);
    chk({15'h0000, ev[7]}, 16'h0001);
    repeat (200) @(negedge clk);
    @(posedge clk);
    irq_pending <= 1'b1;
    pulse(4);
    wait_ev(2, 4);
    chk({15'h0000, ev[2]}, 16'h0001);
    pulse(5);
    @(posedge clk);
    irq_pending <= 1'b0;
    repeat (200) @(negedge clk);
  endtask : t_step

  task t_lowpower;
    pulse(4);
    pulse(6);
    chk({15'h0000, bg_cmd_allowed}, 16'h0000);
    chk({15'h0000, cmd_allowed}, 16'h0001);
    pulse(7);
    wait_ev(3, 4);
    chk({15'h0000, ev[3]}, 16'h0001);
    chk({15'h0000, debug_active}, 16'h0001);
    wait_ev(7, 300);
    chk({15'h0000, ev[7]}, 16'h0000);
    chk({15'h0000, handshake_en}, 16'h0001);
    @(posedge clk);
    sys_stop <= 1'b1;
    repeat (2) @(negedge clk);
    chk({15'h0000, cmd_allowed}, 16'h0000);
    chk({15'h0000, handshake_en}, 16'h0000);
    pulse(4);
    wait_ev(1, 8);
    chk({15'h0000, ev[1]}, 16'h0000);
    @(posedge clk);
    sys_stop <= 1'b0;
  endtask : t_lowpower

  task t_host;
    @(posedge clk);
    next_is_halt <= 1'b1;
    @(negedge clk);
    chk({15'h0000, step_allowed}, 16'h0000);
    pulse(10);
    pulse(11);
    chk({15'h0000, ack_trusted}, 16'h0000);
    pulse(10);
    chk({15'h0000, ack_trusted}, 16'h0001);
  endtask : t_host

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #500000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    pl = 12'h000;
    irq_pending = 1'b0;
    sys_stop = 1'b0;
    send_start = 1'b0;
    next_is_halt = 1'b0;
    send_data = 16'h0000;
    send_bits = 5'h00;
    sys_rst = 1'b1;
    fail_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk({15'h0000, handshake_en}, 16'h0000);
    do_sync();
    t_cmd();
    t_timeout();
    t_read();
    t_abort();
    t_step();
    t_lowpower();
    t_host();
    finish_test();
  end
endmodule : test_debug_line_sync_timeout_trace
